// ===== core/pwmosc_pkg.sv
package pwmosc_pkg;

  typedef struct packed {
    logic [1:0] sw_freq;
    logic high_snr;
    logic noise_shape;
    logic [7:0][3:0] pulse_floor;
    logic [7:0][3:0] gap_time;
  } pwmosc_cfg_t;

  typedef enum logic [2:0] {
    PWMOSC_SQ_OFF = 3'b000,
    PWMOSC_SQ_LEAD = 3'b001,
    PWMOSC_SQ_MINP = 3'b010,
    PWMOSC_SQ_SOFT = 3'b011,
    PWMOSC_SQ_RUN = 3'b100
  } pwmosc_seq_t;

  typedef enum logic [1:0] {
    PWMOSC_SH_IDLE = 2'b00,
    PWMOSC_SH_TIMED = 2'b01,
    PWMOSC_SH_LATCH = 2'b10,
    PWMOSC_SH_WAITON = 2'b11
  } pwmosc_shut_t;

endpackage : pwmosc_pkg

// ===== core/pwmosc_regs.svh
`ifndef PWMOSC_REGS_SVH
`define PWMOSC_REGS_SVH

// Register word addresses
`define PWMOSC_ADDR_MOD 8'h80
`define PWMOSC_ADDR_FLOOR_A 8'h81
`define PWMOSC_ADDR_FLOOR_B 8'h82
`define PWMOSC_ADDR_GAP_A 8'h83
`define PWMOSC_ADDR_GAP_B 8'h84
`define PWMOSC_ADDR_ROUTE_A 8'h85
`define PWMOSC_ADDR_ROUTE_B 8'h86
`define PWMOSC_ADDR_PHONES 8'h87
`define PWMOSC_ADDR_FAULT 8'h88
`define PWMOSC_ADDR_PSE 8'h89
`define PWMOSC_ADDR_RAMP 8'h8a

// Reset values
`define PWMOSC_RST_MOD 16'h0005
`define PWMOSC_RST_FLOOR 16'h6666
`define PWMOSC_RST_GAP 16'h0000
`define PWMOSC_RST_ROUTE_A 16'h1367
`define PWMOSC_RST_ROUTE_B 16'h0245
`define PWMOSC_RST_PHONES 16'h007f
`define PWMOSC_RST_FAULT 16'h208f
`define PWMOSC_RST_PSE 16'h0081
`define PWMOSC_RST_RAMP 16'h8010

// Writable bits per register
`define PWMOSC_MASK_MOD 16'h00ff
`define PWMOSC_MASK_ROUTE 16'h7777
`define PWMOSC_MASK_PHONES 16'h017f
`define PWMOSC_MASK_FAULT 16'h3fff
`define PWMOSC_MASK_PSE 16'h01ff

// Field positions
`define PWMOSC_DC_CUT_BIT 2
`define PWMOSC_DITHER_BIT 3
`define PWMOSC_HSNR_BIT 4
`define PWMOSC_NSHAPE_BIT 5
`define PWMOSC_HP_ON_BIT 8
`define PWMOSC_OVL_POL_BIT 7
`define PWMOSC_OVL_STAT_BIT 15
`define PWMOSC_PSE_TYPE_BIT 7
`define PWMOSC_PSE_USER_BIT 8

// Modulation index multipliers over 32
`define PWMOSC_MI_M0 7'h1d
`define PWMOSC_MI_M1 7'h1e
`define PWMOSC_MI_M2 7'h1f
`define PWMOSC_MI_SHIFT 5

// Sustain codes
`define PWMOSC_SUS_NONE 6'h00
`define PWMOSC_SUS_LATCH 6'h3f

// Timing
`define PWMOSC_REF_HZ 20000000
`define PWMOSC_DET_STEP_NS 667000
`define PWMOSC_SUS_STEP_NS 85300000
`define PWMOSC_LEAD_STEP_NS 5330000
`define PWMOSC_SOFT_STEP_NS 667000
`define PWMOSC_MINP_STEP_NS 83000

`endif

// ===== core/pwmosc_top.sv
// Operation
// - Modulation index code picks 90.63, 93.75 (reset) or 96.88 percent gain.
// - Bit 2 set removes DC from modulator input; set after reset.
// - Bit 3 adds dither only while one; zero at reset.
// - Bit 4 selects high signal-to-noise mode; normal after reset.
// - Bit 5 enables high-bandwidth noise shaping; cleared at reset.
// - Bits 7:6 pick 384, 192, 96 or 384 kHz switching.
// - Minimum pulse is (setting plus two) times 10 ns; resets to 0110.
// - Pulse floor nibbles in output order across two registers.
// - Dead time is setting times 5 ns per output; zero after reset.
// - Three-bit code routes one internal channel to each output.
// - Route codes at bits 2:0,6:4,10:8,14:12; gaps reserved.
// - Bit 8 of headphone register enters headphone mode; off at reset.
// - In headphone mode, channels with off bits set are silenced.
// - Overload declared after input held for count of 0.667 ms steps.
// - Bit 7 sets overload input polarity; active high after reset.
// - Overload shuts all outputs for sustain steps; 0 none, 3f latched.
// - Bit 15 shows external input if sustain zero, else internal state.
// - Power stage enable from bit 8, or from global switch when linked.
// - Linked mode leads PWM start by count of 5.33 ms steps.
// - Soft start over 0.667 ms steps; minimum pulse hold over 0.083 ms steps.
`include "pwmosc_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module pwmosc_top
  import pwmosc_pkg::*;
#(
  parameter int unsigned SW = 24,
  parameter int unsigned REF_HZ = `PWMOSC_REF_HZ,
  parameter int unsigned DET_STEP_CYC =
    int'((64'(`PWMOSC_DET_STEP_NS) * REF_HZ + 64'd999999999) / 64'd1000000000),
  parameter int unsigned SUS_STEP_CYC =
    int'((64'(`PWMOSC_SUS_STEP_NS) * REF_HZ + 64'd999999999) / 64'd1000000000),
  parameter int unsigned LEAD_STEP_CYC =
    int'((64'(`PWMOSC_LEAD_STEP_NS) * REF_HZ + 64'd999999999) / 64'd1000000000),
  parameter int unsigned SOFT_STEP_CYC =
    int'((64'(`PWMOSC_SOFT_STEP_NS) * REF_HZ + 64'd999999999) / 64'd1000000000)
) (
  input wire logic ref_clk, // Core clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic [7:0] reg_addr, // Register word address
  input wire logic [15:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [15:0] reg_rdata, // Read data, one cycle after reg_rd
  output logic reg_rvalid, // Read data valid
  input wire logic pwm_global_off, // Global PWM switch, 1 = off
  input wire logic [7:0][SW-1:0] ch_in, // Internal channels, signed
  input wire logic overload_in, // Overload pin from power stage
  output logic [7:0][SW-1:0] pwm_sample, // Scaled sample per PWM output
  output var pwmosc_cfg_t mod_cfg, // Modulator timing and mode settings
  output logic sub_line_mute, // Subwoofer line-out silenced
  output logic pwm_enable, // PWM outputs switching
  output logic soft_ramp, // Soft start in progress
  output logic min_pulse_hold, // Minimum pulse phase
  output logic power_stage_enable, // External power stage enable
  output logic overload_flag // Overload monitor bit
);

  localparam int unsigned MINP_STEP_CYC =
    int'((64'(`PWMOSC_MINP_STEP_NS) * REF_HZ + 64'd999999999) / 64'd1000000000);
  localparam int unsigned DC_SH = 10;

  logic [15:0] modulator_setup;
  logic [15:0] pulse_floor_ch1_4;
  logic [15:0] pulse_floor_ch5_8;
  logic [15:0] gap_time_ch1_4;
  logic [15:0] gap_time_ch5_8;
  logic [15:0] channel_route_a;
  logic [15:0] channel_route_b;
  logic [15:0] phones_setup;
  logic [13:0] fault_guard;
  logic [15:0] power_stage_enable_timing;
  logic [15:0] ramp_setup;
  logic ovl_meta;
  logic ovl_sync;
  logic ovl_act;
  logic [31:0] det_tick;
  logic [6:0] det_step;
  logic ovl_det;
  logic [31:0] seq_tick;
  logic [7:0] seq_step;
  logic [31:0] seq_len;
  logic [7:0] seq_target;
  logic seq_done;
  logic [31:0] sus_tick;
  logic [5:0] sus_step;
  logic [15:0] lfsr;
  logic shut_active;
  logic [5:0] sus_code;
  logic linked;
  pwmosc_seq_t seq_state;
  pwmosc_seq_t next_seq_state;
  pwmosc_shut_t shut_state;
  pwmosc_shut_t next_shut_state;

  assign sus_code = fault_guard[13:8];
  assign linked = power_stage_enable_timing[`PWMOSC_PSE_TYPE_BIT];

  // Register writes; reserved bits masked off
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      modulator_setup <= `PWMOSC_RST_MOD;
      pulse_floor_ch1_4 <= `PWMOSC_RST_FLOOR;
      pulse_floor_ch5_8 <= `PWMOSC_RST_FLOOR;
      gap_time_ch1_4 <= `PWMOSC_RST_GAP;
      gap_time_ch5_8 <= `PWMOSC_RST_GAP;
      channel_route_a <= `PWMOSC_RST_ROUTE_A;
      channel_route_b <= `PWMOSC_RST_ROUTE_B;
      phones_setup <= `PWMOSC_RST_PHONES;
      fault_guard <= 14'(`PWMOSC_RST_FAULT);
      power_stage_enable_timing <= `PWMOSC_RST_PSE;
      ramp_setup <= `PWMOSC_RST_RAMP;
    end else if (reg_wr) begin
      case (reg_addr)
        `PWMOSC_ADDR_MOD: modulator_setup <= reg_wdata & `PWMOSC_MASK_MOD;
        `PWMOSC_ADDR_FLOOR_A: pulse_floor_ch1_4 <= reg_wdata;
        `PWMOSC_ADDR_FLOOR_B: pulse_floor_ch5_8 <= reg_wdata;
        `PWMOSC_ADDR_GAP_A: gap_time_ch1_4 <= reg_wdata;
        `PWMOSC_ADDR_GAP_B: gap_time_ch5_8 <= reg_wdata;
        `PWMOSC_ADDR_ROUTE_A: channel_route_a <= reg_wdata & `PWMOSC_MASK_ROUTE;
        `PWMOSC_ADDR_ROUTE_B: channel_route_b <= reg_wdata & `PWMOSC_MASK_ROUTE;
        `PWMOSC_ADDR_PHONES: phones_setup <= reg_wdata & `PWMOSC_MASK_PHONES;
        `PWMOSC_ADDR_FAULT: fault_guard <= reg_wdata[13:0];
        `PWMOSC_ADDR_PSE: power_stage_enable_timing <= reg_wdata & `PWMOSC_MASK_PSE;
        `PWMOSC_ADDR_RAMP: ramp_setup <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read port; unmapped addresses return zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `PWMOSC_ADDR_MOD: reg_rdata <= modulator_setup;
          `PWMOSC_ADDR_FLOOR_A: reg_rdata <= pulse_floor_ch1_4;
          `PWMOSC_ADDR_FLOOR_B: reg_rdata <= pulse_floor_ch5_8;
          `PWMOSC_ADDR_GAP_A: reg_rdata <= gap_time_ch1_4;
          `PWMOSC_ADDR_GAP_B: reg_rdata <= gap_time_ch5_8;
          `PWMOSC_ADDR_ROUTE_A: reg_rdata <= channel_route_a;
          `PWMOSC_ADDR_ROUTE_B: reg_rdata <= channel_route_b;
          `PWMOSC_ADDR_PHONES: reg_rdata <= phones_setup;
          `PWMOSC_ADDR_FAULT: reg_rdata <= {overload_flag, 1'b0, fault_guard};
          `PWMOSC_ADDR_PSE: reg_rdata <= power_stage_enable_timing;
          `PWMOSC_ADDR_RAMP: reg_rdata <= ramp_setup;
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // Settings handed to the switching modulator
  assign mod_cfg.sw_freq = modulator_setup[7:6];
  assign mod_cfg.high_snr = modulator_setup[`PWMOSC_HSNR_BIT];
  assign mod_cfg.noise_shape = modulator_setup[`PWMOSC_NSHAPE_BIT];
  assign mod_cfg.pulse_floor = {pulse_floor_ch5_8, pulse_floor_ch1_4};
  assign mod_cfg.gap_time = {gap_time_ch5_8, gap_time_ch1_4};

  // Overload pin synchroniser
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ovl_meta <= 1'b0;
      ovl_sync <= 1'b0;
    end else begin
      ovl_meta <= overload_in;
      ovl_sync <= ovl_meta;
    end
  end

  assign ovl_act = fault_guard[`PWMOSC_OVL_POL_BIT] ? ovl_sync : ~ovl_sync;
  assign ovl_det = ovl_act && (det_step >= fault_guard[6:0]);

  // Qualification timer restarts whenever the input drops
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !ovl_act) begin
      det_tick <= 32'h0;
      det_step <= 7'h00;
    end else if (det_tick == DET_STEP_CYC - 1) begin
      det_tick <= 32'h0;
      if (det_step != 7'h7f) begin
        det_step <= det_step + 7'h01;
      end
    end else begin
      det_tick <= det_tick + 32'h1;
    end
  end

  // Shutdown control
  always_comb begin
    next_shut_state = shut_state;
    case (shut_state)
      PWMOSC_SH_IDLE: begin
        if (ovl_det && sus_code != `PWMOSC_SUS_NONE) begin
          next_shut_state = (sus_code == `PWMOSC_SUS_LATCH) ? PWMOSC_SH_LATCH : PWMOSC_SH_TIMED;
        end
      end
      PWMOSC_SH_TIMED: begin
        if (sus_step >= sus_code) begin
          next_shut_state = PWMOSC_SH_IDLE;
        end
      end
      PWMOSC_SH_LATCH: begin
        if (pwm_global_off) begin
          next_shut_state = PWMOSC_SH_WAITON;
        end
      end
      PWMOSC_SH_WAITON: begin
        if (!pwm_global_off) begin
          next_shut_state = PWMOSC_SH_IDLE;
        end
      end
      default: next_shut_state = PWMOSC_SH_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      shut_state <= PWMOSC_SH_IDLE;
    end else begin
      shut_state <= next_shut_state;
    end
  end

  assign shut_active = (shut_state != PWMOSC_SH_IDLE);

  always_ff @(posedge ref_clk) begin
    if (sys_rst || shut_state != PWMOSC_SH_TIMED) begin
      sus_tick <= 32'h0;
      sus_step <= 6'h00;
    end else if (sus_tick == SUS_STEP_CYC - 1) begin
      sus_tick <= 32'h0;
      sus_step <= sus_step + 6'h01;
    end else begin
      sus_tick <= sus_tick + 32'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      overload_flag <= 1'b0;
    end else begin
      overload_flag <= (sus_code == `PWMOSC_SUS_NONE) ? ovl_act : shut_active;
    end
  end

  // Start sequence: lead, minimum pulse, soft ramp, run
  always_comb begin
    seq_len = 32'(MINP_STEP_CYC);
    seq_target = 8'h00;
    case (seq_state)
      PWMOSC_SQ_LEAD: begin
        seq_len = 32'(LEAD_STEP_CYC);
        seq_target = linked ? {1'b0, power_stage_enable_timing[6:0]} : 8'h00;
      end
      PWMOSC_SQ_MINP: begin
        seq_len = 32'(MINP_STEP_CYC);
        seq_target = ramp_setup[15:8];
      end
      PWMOSC_SQ_SOFT: begin
        seq_len = 32'(SOFT_STEP_CYC);
        seq_target = ramp_setup[7:0];
      end
      default: ;
    endcase
  end

  assign seq_done = (seq_step >= seq_target);

  always_comb begin
    next_seq_state = seq_state;
    if (pwm_global_off) begin
      next_seq_state = PWMOSC_SQ_OFF;
    end else begin
      case (seq_state)
        PWMOSC_SQ_OFF: begin
          if (!shut_active) begin
            next_seq_state = PWMOSC_SQ_LEAD;
          end
        end
        PWMOSC_SQ_LEAD: next_seq_state = seq_done ? PWMOSC_SQ_MINP : PWMOSC_SQ_LEAD;
        PWMOSC_SQ_MINP: next_seq_state = seq_done ? PWMOSC_SQ_SOFT : PWMOSC_SQ_MINP;
        PWMOSC_SQ_SOFT: next_seq_state = seq_done ? PWMOSC_SQ_RUN : PWMOSC_SQ_SOFT;
        PWMOSC_SQ_RUN: ;
        default: next_seq_state = PWMOSC_SQ_OFF;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      seq_state <= PWMOSC_SQ_OFF;
    end else begin
      seq_state <= next_seq_state;
    end
  end

  // Step timer restarts on every state change
  always_ff @(posedge ref_clk) begin
    if (sys_rst || next_seq_state != seq_state) begin
      seq_tick <= 32'h0;
      seq_step <= 8'h00;
    end else if (seq_tick >= seq_len - 32'h1) begin
      seq_tick <= 32'h0;
      if (seq_step != 8'hff) begin
        seq_step <= seq_step + 8'h01;
      end
    end else begin
      seq_tick <= seq_tick + 32'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pwm_enable <= 1'b0;
      soft_ramp <= 1'b0;
      min_pulse_hold <= 1'b0;
      power_stage_enable <= 1'b0;
    end else begin
      pwm_enable <= !shut_active && (next_seq_state == PWMOSC_SQ_MINP ||
        next_seq_state == PWMOSC_SQ_SOFT || next_seq_state == PWMOSC_SQ_RUN);
      soft_ramp <= (next_seq_state == PWMOSC_SQ_SOFT);
      min_pulse_hold <= (next_seq_state == PWMOSC_SQ_MINP);
      power_stage_enable <= linked ? (next_seq_state != PWMOSC_SQ_OFF)
        : power_stage_enable_timing[`PWMOSC_PSE_USER_BIT];
    end
  end

  // Dither source; one LSB of noise is enough to break idle tones
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lfsr <= 16'hace1;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sub_line_mute <= 1'b0;
    end else begin
      sub_line_mute <= phones_setup[`PWMOSC_HP_ON_BIT] && phones_setup[6];
    end
  end

  genvar o;
  generate
    for (o = 0; o < 8; o++) begin : g_out
      logic [2:0] src;
      logic muted;
      logic signed [SW-1:0] x;
      logic signed [SW-1:0] dc_est;
      logic signed [SW:0] diff;
      logic signed [SW:0] y;
      logic [6:0] mult;
      logic signed [SW+7:0] prod;
      logic signed [SW+7:0] scaled;
      logic signed [SW+7:0] hi_lim;
      logic signed [SW+7:0] lo_lim;

      assign src = (o < 4) ? channel_route_a[4*(o%4) +: 3] : channel_route_b[4*(o%4) +: 3];
      assign x = $signed(ch_in[src]);
      // Front channels have no headphone off bit and always pass
      assign muted = phones_setup[`PWMOSC_HP_ON_BIT] && (src >= 3'd2) &&
        phones_setup[src - 3'd2];
      assign diff = {x[SW-1], x} - {dc_est[SW-1], dc_est};
      assign y = modulator_setup[`PWMOSC_DC_CUT_BIT] ? diff : {x[SW-1], x};
      always_comb begin
        case (modulator_setup[1:0])
          2'b00: mult = `PWMOSC_MI_M0;
          2'b10: mult = `PWMOSC_MI_M2;
          default: mult = `PWMOSC_MI_M1;
        endcase
      end
      assign prod = (SW+8)'(y * $signed({1'b0, mult}));
      assign scaled = (prod >>> `PWMOSC_MI_SHIFT) +
        (SW+8)'(modulator_setup[`PWMOSC_DITHER_BIT] & lfsr[o]);
      assign hi_lim = (SW+8)'({1'b0, {(SW-1){1'b1}}});
      assign lo_lim = -hi_lim - (SW+8)'(1);

      // Slow leaky average tracks the DC offset
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          dc_est <= '0;
        end else begin
          dc_est <= SW'(dc_est + (diff >>> DC_SH));
        end
      end

      always_ff @(posedge ref_clk) begin
        if (sys_rst || muted || !pwm_enable) begin
          pwm_sample[o] <= '0;
        end else if (scaled > hi_lim) begin
          pwm_sample[o] <= hi_lim[SW-1:0];
        end else if (scaled < lo_lim) begin
          pwm_sample[o] <= lo_lim[SW-1:0];
        end else begin
          pwm_sample[o] <= scaled[SW-1:0];
        end
      end
    end
  endgenerate

  sequence s_latch_entry;
    (shut_state == PWMOSC_SH_LATCH) ##1 pwm_global_off;
  endsequence
  sequence s_rearm;
    (shut_state == PWMOSC_SH_WAITON) && !pwm_global_off;
  endsequence

  mod_reset_a: assert property (@(posedge ref_clk)
    sys_rst |=> modulator_setup == 16'h0005 && phones_setup == 16'h007f)
    else $error("reset values wrong");
  // Compares against the pin two edges back, so a broken synchroniser shows up too
  ovl_polar_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !fault_guard[`PWMOSC_OVL_POL_BIT] && !$past(sys_rst) && !$past(sys_rst, 2) |->
    ovl_act == !$past(overload_in, 2)) else $error("polarity");
  det_early_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (shut_state == PWMOSC_SH_IDLE) ##1 (shut_state != PWMOSC_SH_IDLE) |->
    $past(ovl_act) && $past(det_step) >= $past(fault_guard[6:0])) else $error("early");
  no_shut_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (sus_code == 6'h00) && !shut_active |=> !shut_active) else $error("shut at zero");
  shut_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    shut_active |=> !pwm_enable) else $error("outputs on in shutdown");
  recover_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_latch_entry ##1 s_rearm |=> shut_state == PWMOSC_SH_IDLE) else $error("no recovery");
  stat_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reg_rd && reg_addr == 8'h88 |=> reg_rvalid && reg_rdata[15] == $past(overload_flag) &&
    reg_rdata[14] == 1'b0) else $error("status read");
  pse_user_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !linked ##1 !linked |-> power_stage_enable == $past(power_stage_enable_timing[8]))
    else $error("user enable");
  lead_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    seq_state == PWMOSC_SQ_LEAD && linked |-> power_stage_enable && !pwm_enable)
    else $error("lead");
  rsv_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reg_rd && reg_addr == 8'h85 |=> (reg_rdata & 16'h8888) == 16'h0000)
    else $error("reserved bits");

endmodule : pwmosc_top

`default_nettype wire

// ===== test/pwmosc_power_stage.sv
`timescale 1ns/10ps
`default_nettype none

// The stage flags a fault only while it is powered.
// With its supply off it cannot report anything.
module pwmosc_power_stage (
  input wire logic power_stage_enable, // Supply enable from controller
  input wire logic fault_cmd, // Bench request for an overload
  input wire logic active_high, // Pin polarity strapped on the stage
  output logic overload_in // Overload pin toward controller
);
  logic fault;
  assign fault = fault_cmd & power_stage_enable;
  assign overload_in = active_high ? fault : ~fault;
endmodule : pwmosc_power_stage

`default_nettype wire

// ===== test/pwmosc_top_tb.sv
`timescale 1ns/10ps
`default_nettype none

module pwmosc_top_tb;
  import pwmosc_pkg::*;
  localparam int SW = 24;
  logic ref_clk, sys_rst, reg_wr, reg_rd, reg_rvalid, pwm_global_off, overload_in;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [7:0][SW-1:0] ch_in, pwm_sample;
  pwmosc_cfg_t mod_cfg;
  logic sub_line_mute, pwm_enable, soft_ramp, min_pulse_hold, power_stage_enable;
  logic overload_flag, fault_cmd, active_high;
  int n_errors = 0, check_count = 0, cyc = 0, n;
  // Address, reset value, value written, value read back
  localparam logic [15:0] T [11][4] = '{'{16'h0080, 16'h0005, 16'hffff, 16'h00ff},
    '{16'h0081, 16'h6666, 16'hfedc, 16'hfedc}, '{16'h0082, 16'h6666, 16'h1234, 16'h1234},
    '{16'h0083, 16'h0000, 16'h5a5a, 16'h5a5a}, '{16'h0084, 16'h0000, 16'ha5a5, 16'ha5a5},
    '{16'h0085, 16'h1367, 16'hffff, 16'h7777}, '{16'h0086, 16'h0245, 16'h8888, 16'h0000},
    '{16'h0087, 16'h007f, 16'hffff, 16'h017f}, '{16'h0088, 16'h208f, 16'hffff, 16'h3fff},
    '{16'h0089, 16'h0081, 16'hffff, 16'h01ff}, '{16'h007f, 16'h0000, 16'hffff, 16'h0000}};
  localparam int GAIN [4] = '{29, 30, 31, 30};

  pwmosc_top #(.SW(SW), .DET_STEP_CYC(4), .SUS_STEP_CYC(8), .LEAD_STEP_CYC(6),
    .SOFT_STEP_CYC(4)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .pwm_global_off(pwm_global_off), .ch_in(ch_in),
    .overload_in(overload_in), .pwm_sample(pwm_sample), .mod_cfg(mod_cfg),
    .sub_line_mute(sub_line_mute), .pwm_enable(pwm_enable), .soft_ramp(soft_ramp),
    .min_pulse_hold(min_pulse_hold), .power_stage_enable(power_stage_enable),
    .overload_flag(overload_flag));
  pwmosc_power_stage stage (.power_stage_enable(power_stage_enable),
    .fault_cmd(fault_cmd), .active_high(active_high), .overload_in(overload_in));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // The whole run needs well under two thousand cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    chk("read valid", reg_rvalid, 1'b1);
    d = reg_rdata;
  endtask : rd

  function automatic logic sig(input int s);
    return s == 0 ? pwm_enable : s == 1 ? power_stage_enable : soft_ramp | min_pulse_hold;
  endfunction : sig

  task automatic wt(input int s, input logic v, input int lim);
    for (n = 0; n < lim && sig(s) !== v; n++) @(negedge ref_clk);
  endtask : wt

  task automatic chk_out(input logic [15:0] ra, rb, input logic [7:0] mute, input int m);
    logic [2:0] c;
    repeat (4) @(negedge ref_clk);
    for (int k = 0; k < 8; k++) begin
      c = k < 4 ? ra[4*k+:3] : rb[4*(k-4)+:3];
      chk("sample", 32'(pwm_sample[k]), mute[c] ? 32'h0 : 32'(8 * (c + 1) * m));
    end
  endtask : chk_out

  task automatic reset_dut;
    sys_rst = 1'b1;
    repeat (6) @(negedge ref_clk);
    sys_rst = 1'b0;
  endtask : reset_dut

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  initial begin
    logic [15:0] d;
    logic [7:0] hits;
    logic [2:0] s;
    {reg_wr, reg_rd, fault_cmd, reg_addr, reg_wdata} = '0;
    pwm_global_off = 1'b1;
    active_high = 1'b1;
    for (int i = 0; i < 8; i++) ch_in[i] = 24'((i + 1) * 256);
    reset_dut();
    chk("floor reset", mod_cfg.pulse_floor, 32'h66666666);
    foreach (T[i]) begin
      rd(T[i][0][7:0], d);
      chk("reset value", d, T[i][1]);
      wr(T[i][0][7:0], T[i][2]);
      rd(T[i][0][7:0], d);
      chk("readback", d, T[i][3]);
    end
    chk("floor", mod_cfg.pulse_floor, 32'h1234fedc);
    chk("gap", mod_cfg.gap_time, 32'ha5a55a5a);
    chk("mode", {mod_cfg.sw_freq, mod_cfg.high_snr, mod_cfg.noise_shape}, 4'hf);
    $display("test registers finished");
    reset_dut();
    rd(8'h88, d);
    chk("second reset", d, 16'h208f);
    // Short ramp keeps the start-up inside the run budget
    wr(8'h8a, 16'h0001);
    wr(8'h80, 16'h0001);
    pwm_global_off = 1'b0;
    wt(1, 1'b1, 4);
    chk("enable lead", power_stage_enable, 1'b1);
    wt(0, 1'b1, 40);
    chk("lead time", n >= 6 && n < 10, 1'b1);
    chk("min pulse", {min_pulse_hold, soft_ramp}, 2'b10);
    wt(2, 1'b0, 40);
    chk("ramp time", n >= 4 && n < 10, 1'b1);
    chk_out(16'h1367, 16'h0245, 8'h00, 30);
    foreach (GAIN[c]) begin
      wr(8'h80, 16'(c));
      chk_out(16'h1367, 16'h0245, 8'h00, GAIN[c]);
    end
    wr(8'h87, 16'h017f);
    chk_out(16'h1367, 16'h0245, 8'hfc, 30);
    chk("line mute", sub_line_mute, 1'b1);
    wr(8'h87, 16'h0140);
    chk_out(16'h1367, 16'h0245, 8'h00, 30);
    wr(8'h87, 16'h007f);
    chk_out(16'h1367, 16'h0245, 8'h00, 30);
    chk("line mute off", sub_line_mute, 1'b0);
    wr(8'h86, 16'h7654);
    chk_out(16'h1367, 16'h7654, 8'h00, 30);
    // Output 1 carries a constant input; with the cut on it must fall below the plain gain
    wr(8'h80, 16'h0005);
    repeat (2) @(negedge ref_clk);
    chk("dc cut", 32'(pwm_sample[0]) < 32'd1920 && pwm_sample[0] != '0, 1'b1);
    wr(8'h80, 16'h0009);
    hits = '0;
    repeat (4) begin
      @(negedge ref_clk);
      for (int k = 0; k < 8; k++) begin
        s = k < 4 ? 3'(16'h1367 >> (4 * k)) : 3'(k);
        hits[k] = hits[k] | (32'(pwm_sample[k]) != 32'(8 * (s + 1) * 30));
        chk("dither", 32'(pwm_sample[k]) - 32'(8 * (s + 1) * 30) <= 32'd1, 1'b1);
      end
    end
    chk("dither seen", |hits, 1'b1);
    $display("test datapath finished");
    wr(8'h88, 16'h0283);
    fault_cmd = 1'b1;
    wt(0, 1'b0, 60);
    chk("detect time", n >= 12 && n < 30, 1'b1);
    rd(8'h88, d);
    chk("flag read", d, 16'h8283);
    fault_cmd = 1'b0;
    wt(0, 1'b1, 80);
    chk("sustain time", n >= 8 && n < 40, 1'b1);
    chk("flag clear", overload_flag, 1'b0);
    wr(8'h88, 16'h3f03);
    active_high = 1'b0;
    fault_cmd = 1'b1;
    wt(0, 1'b0, 60);
    fault_cmd = 1'b0;
    repeat (60) @(negedge ref_clk);
    chk("latched", {pwm_enable, overload_flag}, 2'b01);
    pwm_global_off = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("global off", {power_stage_enable, pwm_enable}, 2'b00);
    pwm_global_off = 1'b0;
    wt(0, 1'b1, 100);
    chk("recovered", pwm_enable, 1'b1);
    wr(8'h88, 16'h0083);
    active_high = 1'b1;
    fault_cmd = 1'b1;
    repeat (5) @(negedge ref_clk);
    chk("direct flag", {overload_flag, pwm_enable}, 2'b11);
    fault_cmd = 1'b0;
    repeat (5) @(negedge ref_clk);
    chk("direct clear", overload_flag, 1'b0);
    wr(8'h89, 16'h0100);
    pwm_global_off = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("user enable", power_stage_enable, 1'b1);
    wr(8'h89, 16'h0000);
    repeat (2) @(negedge ref_clk);
    chk("user disable", power_stage_enable, 1'b0);
    $display("test overload and enable finished");
    test_done();
  end
endmodule : pwmosc_top_tb

`default_nettype wire
